// ==== hdl/spd_pkg.sv ====
// Constants and types for the presence-detect memory and temperature sensor slave.
package spd_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_MS = 125;
    localparam int CONV_CYC = CLK_HZ / 1000 * CONV_MS;
    localparam int TOUT_MS = 25;
    localparam int TOUT_CYC = CLK_HZ / 1000 * TOUT_MS;
    localparam int CW = 23;
    localparam int MEM_BYTES = 512;
    localparam int TEMP_BITS = 11;
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_TS = 4'h3;
    localparam logic [3:0] TYPE_CMD = 4'h6;
    localparam logic [2:0] CMD_CLR_WP = 3'h4;
    localparam logic [2:0] CMD_PAGE0 = 3'h6;
    localparam logic [2:0] CMD_PAGE1 = 3'h7;
    localparam logic [2:0] PTR_CAP = 3'h0;
    localparam logic [2:0] PTR_CFG = 3'h1;
    localparam logic [2:0] PTR_UPPER = 3'h2;
    localparam logic [2:0] PTR_LOWER = 3'h3;
    localparam logic [2:0] PTR_CRIT = 3'h4;
    localparam logic [2:0] PTR_TEMP = 3'h5;
    localparam logic [2:0] PTR_MFG = 3'h6;
    localparam logic [2:0] PTR_DEV = 3'h7;
    localparam int CFG_EN = 0;
    localparam int CFG_INT = 1;
    localparam int CFG_CRIT = 2;
    localparam int CFG_CLR = 5;
    localparam logic [15:0] CAP_VALUE = 16'h0001;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACKO = 5'h04,
        ST_SEND = 5'h08,
        ST_ACKI = 5'h10
    } spd_state_type;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] crit;
    } spd_limits_type;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } spd_bus_ev_type;
endpackage : spd_pkg

// ==== hdl/spd_eeprom_temp_sensor_slave.sv ====
// Two-wire slave with 512-byte memory, quadrant protection and temperature alert.
`timescale 1ns/100ps
`default_nettype none

module spd_eeprom_temp_sensor_slave #(
    parameter int CONV_CYC = spd_pkg::CONV_CYC, // Conversion period in ref_clk cycles.
    parameter int TOUT_CYC = spd_pkg::TOUT_CYC, // Bus timeout in ref_clk cycles.
    parameter logic [15:0] MFG_ID = 16'h1234, // Arbitrary value.
    parameter logic [15:0] DEV_ID = 16'h5678 // Arbitrary value.
) (
    input wire logic ref_clk, // System clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic scl_clk, // Serial clock pin.
    input wire logic sda_i, // Serial data pin level.
    output logic sda_o, // Serial data drive value.
    output logic sda_oe_n, // Low while pulling data low.
    input wire logic [2:0] address_select_inputs, // Strap pins.
    input wire logic [10:0] temp_in, // Converter result.
    output logic event_o, // Alert drive value.
    output logic event_oe_n // Low while the alert is asserted.
);

    // Link side: only the raw sample and an event toggle live on the serial clock.
    logic link_bit_q;
    logic link_tog_q;

    always_ff @(posedge scl_clk or posedge reset) begin
        if (reset) begin
            link_bit_q <= 1'b0;
            link_tog_q <= 1'b0;
        end else begin
            link_bit_q <= sda_i;
            link_tog_q <= ~link_tog_q;
        end
    end

    // Synchronisers into the ref_clk domain.
    logic [2:0] tog_s_q;
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic scl_p_q;
    logic sda_p_q;
    logic [2:0] as1_q;
    logic [2:0] as2_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tog_s_q <= 3'h0;
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            as1_q <= 3'h0;
            as2_q <= 3'h0;
        end else begin
            tog_s_q <= {tog_s_q[1:0], link_tog_q};
            scl_s_q <= {scl_s_q[0], scl_clk};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
            as1_q <= address_select_inputs;
            as2_q <= as1_q;
        end
    end

    // The sampled bit is stable for a whole clock period after its toggle lands.
    spd_pkg::spd_bus_ev_type ev;
    assign ev.start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign ev.stop = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    assign ev.rise = tog_s_q[2] ^ tog_s_q[1];
    assign ev.fall = scl_p_q & ~scl_s_q[1];

    // Bus timeout.
    logic [spd_pkg::CW-1:0] to_q;
    wire logic tout = to_q == spd_pkg::CW'(TOUT_CYC - 1);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            to_q <= '0;
        end else begin
            to_q <= (scl_s_q[1] | tout) ? '0 : to_q + 1'b1;
        end
    end

    // Protocol state.
    spd_pkg::spd_state_type st_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [1:0] nb_q;
    logic rw_q;
    logic is_mem_q;
    logic is_ts_q;
    logic ack_q;
    logic drv_q;
    logic sda_oe_n_q;
    logic sda_o_q;
    logic [7:0] addr_q;
    logic spa_q;
    logic [3:0] wp_q;
    logic [2:0] ptr_q;
    logic bsel_q;
    logic [7:0] whi_q;
    logic [15:0] cfg_q;
    logic [15:0] temp_q;
    spd_pkg::spd_limits_type lim_q;
    logic [7:0] mem_q [0:spd_pkg::MEM_BYTES-1];

    wire logic [7:0] rx_byte = {sh_q[6:0], link_bit_q};
    wire logic straps_ok = rx_byte[3:1] == as2_q;
    wire logic hit_mem = rx_byte[7:4] == spd_pkg::TYPE_MEM && straps_ok;
    wire logic hit_ts = rx_byte[7:4] == spd_pkg::TYPE_TS && straps_ok;
    wire logic hit_cmd = rx_byte[7:4] == spd_pkg::TYPE_CMD;
    wire logic [2:0] cmd = rx_byte[3:1];
    wire logic [8:0] mem_idx = {spa_q, addr_q};
    wire logic wp_hit = wp_q[mem_idx[8:7]];
    wire logic ts_wr_ok = ptr_q >= spd_pkg::PTR_CFG && ptr_q <= spd_pkg::PTR_CRIT;
    wire logic byte_done = st_q == spd_pkg::ST_RECV && ev.rise && cnt_q == 3'h7;
    wire logic first = nb_q == 2'h0;
    wire logic data = nb_q == 2'h2;
    wire logic mem_we = byte_done & is_mem_q & data & ~wp_hit;
    wire logic ts_we = byte_done & is_ts_q & data & ts_wr_ok & bsel_q;
    wire logic cmd_wr = byte_done & first & hit_cmd & ~rx_byte[0];
    wire logic [15:0] ts_wdata = {whi_q, rx_byte};
    wire logic send_next = rw_q & (is_mem_q | is_ts_q);
    wire logic recv_next = ~rw_q & (is_mem_q | is_ts_q);

    logic [15:0] ts_rd;
    always_comb begin
        unique case (ptr_q)
            spd_pkg::PTR_CAP: ts_rd = spd_pkg::CAP_VALUE;
            spd_pkg::PTR_CFG: ts_rd = cfg_q;
            spd_pkg::PTR_UPPER: ts_rd = lim_q.upper;
            spd_pkg::PTR_LOWER: ts_rd = lim_q.lower;
            spd_pkg::PTR_CRIT: ts_rd = lim_q.crit;
            spd_pkg::PTR_TEMP: ts_rd = temp_q;
            spd_pkg::PTR_MFG: ts_rd = MFG_ID;
            spd_pkg::PTR_DEV: ts_rd = DEV_ID;
        endcase
    end

    wire logic [7:0] rd_byte = is_mem_q ? mem_q[mem_idx] : (bsel_q ? ts_rd[7:0] : ts_rd[15:8]);

    // Page reads answer with acknowledge only when the asked half is selected.
    logic ack_d;
    always_comb begin
        ack_d = 1'b0;
        if (first) begin
            ack_d = hit_mem | hit_ts | (hit_cmd & ~rx_byte[0]);
            if (hit_cmd && rx_byte[0]) begin
                ack_d = (cmd == spd_pkg::CMD_PAGE0 && !spa_q) ||
                    (cmd == spd_pkg::CMD_PAGE1 && spa_q);
            end
        end else if (!data) begin
            ack_d = 1'b1;
        end else if (is_mem_q) begin
            ack_d = ~wp_hit;
        end else begin
            ack_d = ts_wr_ok;
        end
    end

    // Byte engine; start, stop and timeout override every state.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_q <= spd_pkg::ST_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            nb_q <= 2'h0;
            rw_q <= 1'b0;
            is_mem_q <= 1'b0;
            is_ts_q <= 1'b0;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            addr_q <= 8'h00;
            ptr_q <= 3'h0;
            bsel_q <= 1'b0;
        end else if (ev.start) begin
            st_q <= spd_pkg::ST_RECV;
            cnt_q <= 3'h0;
            nb_q <= 2'h0;
            bsel_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else if (ev.stop || tout) begin
            st_q <= spd_pkg::ST_IDLE;
            sda_oe_n_q <= 1'b1;
        end else begin
            unique case (st_q)
                spd_pkg::ST_IDLE: begin
                    sda_oe_n_q <= 1'b1;
                end
                spd_pkg::ST_RECV: begin
                    if (ev.rise) begin
                        sh_q <= rx_byte;
                        cnt_q <= cnt_q + 3'h1;
                    end
                    if (byte_done) begin
                        ack_q <= ack_d;
                        drv_q <= 1'b0;
                        if (!data) begin
                            nb_q <= nb_q + 2'h1;
                        end
                        if (first) begin
                            rw_q <= rx_byte[0];
                            is_mem_q <= hit_mem;
                            is_ts_q <= hit_ts;
                        end else if (nb_q == 2'h1 && is_mem_q) begin
                            addr_q <= rx_byte;
                        end else if (nb_q == 2'h1) begin
                            ptr_q <= rx_byte[2:0];
                            bsel_q <= 1'b0;
                        end else if (is_mem_q && !wp_hit) begin
                            addr_q <= addr_q + 8'h01;
                        end else if (is_ts_q) begin
                            bsel_q <= ~bsel_q;
                        end
                        st_q <= (first && !(hit_mem || hit_ts || hit_cmd)) ?
                            spd_pkg::ST_IDLE : spd_pkg::ST_ACKO;
                    end
                end
                spd_pkg::ST_ACKO: begin
                    if (ev.fall && !drv_q) begin
                        drv_q <= 1'b1;
                        sda_oe_n_q <= ~ack_q;
                    end else if (ev.fall && ack_q && send_next) begin
                        sh_q <= rd_byte;
                        sda_oe_n_q <= rd_byte[7];
                        st_q <= spd_pkg::ST_SEND;
                        addr_q <= addr_q + {7'h00, is_mem_q};
                        bsel_q <= bsel_q ^ is_ts_q;
                    end else if (ev.fall) begin
                        sda_oe_n_q <= 1'b1;
                        st_q <= (ack_q && recv_next) ? spd_pkg::ST_RECV : spd_pkg::ST_IDLE;
                    end
                end
                spd_pkg::ST_SEND: begin
                    if (ev.fall) begin
                        sda_oe_n_q <= sh_q[7];
                    end
                    if (ev.rise) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            st_q <= spd_pkg::ST_ACKI;
                        end
                    end
                end
                spd_pkg::ST_ACKI: begin
                    if (ev.fall) begin
                        sda_oe_n_q <= 1'b1;
                    end
                    if (ev.rise && !link_bit_q) begin
                        sh_q <= rd_byte;
                        st_q <= spd_pkg::ST_SEND;
                        addr_q <= addr_q + {7'h00, is_mem_q};
                        bsel_q <= bsel_q ^ is_ts_q;
                    end else if (ev.rise) begin
                        st_q <= spd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Page select and quadrant protection commands.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            spa_q <= 1'b0;
            wp_q <= 4'h0;
        end else if (cmd_wr) begin
            if (!cmd[2]) begin
                wp_q[cmd[1:0]] <= 1'b1;
            end else if (cmd == spd_pkg::CMD_CLR_WP) begin
                wp_q <= 4'h0;
            end else if (cmd == spd_pkg::CMD_PAGE0) begin
                spa_q <= 1'b0;
            end else if (cmd == spd_pkg::CMD_PAGE1) begin
                spa_q <= 1'b1;
            end
        end
    end

    // Writes complete in one cycle, so reads never wait on a busy array.
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem_q[mem_idx] <= rx_byte;
        end
    end

    // Sensor registers, conversion and alert.
    logic [spd_pkg::CW-1:0] conv_q;
    logic int_q;
    logic win_q;
    logic event_oe_n_q;
    logic event_o_q;
    wire logic conv_done = conv_q == spd_pkg::CW'(CONV_CYC - 1);
    wire logic [15:0] temp_ext = {{(16 - spd_pkg::TEMP_BITS){temp_in[10]}}, temp_in};
    wire logic above_crit = $signed(temp_q) > $signed(lim_q.crit);
    wire logic out_win = $signed(temp_q) > $signed(lim_q.upper) ||
        $signed(temp_q) < $signed(lim_q.lower) || above_crit;
    wire logic int_clr = ts_we && ptr_q == spd_pkg::PTR_CFG && rx_byte[spd_pkg::CFG_CLR];
    wire logic alert_on = cfg_q[spd_pkg::CFG_EN] & (cfg_q[spd_pkg::CFG_CRIT] ? above_crit :
        (cfg_q[spd_pkg::CFG_INT] ? int_q : out_win));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            whi_q <= 8'h00;
            cfg_q <= spd_pkg::CFG_RESET;
            lim_q <= {3{spd_pkg::LIMIT_RESET}};
        end else begin
            if (byte_done && is_ts_q && data && !bsel_q) begin
                whi_q <= rx_byte;
            end
            if (ts_we && ptr_q == spd_pkg::PTR_CFG) begin
                cfg_q <= ts_wdata;
                cfg_q[spd_pkg::CFG_CLR] <= 1'b0;
            end
            if (ts_we && ptr_q == spd_pkg::PTR_UPPER) begin
                lim_q.upper <= ts_wdata;
            end
            if (ts_we && ptr_q == spd_pkg::PTR_LOWER) begin
                lim_q.lower <= ts_wdata;
            end
            if (ts_we && ptr_q == spd_pkg::PTR_CRIT) begin
                lim_q.crit <= ts_wdata;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            conv_q <= '0;
            temp_q <= 16'h0000;
        end else begin
            conv_q <= conv_done ? '0 : conv_q + 1'b1;
            if (conv_done) begin
                temp_q <= temp_ext;
            end
        end
    end

    // A new excursion sets the interrupt even in the cycle software clears it.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            win_q <= 1'b0;
            int_q <= 1'b0;
            event_oe_n_q <= 1'b1;
            event_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end else begin
            win_q <= out_win;
            int_q <= (out_win & ~win_q) | (int_q & ~int_clr);
            event_oe_n_q <= ~alert_on;
            event_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe_n = sda_oe_n_q;
    assign event_o = event_o_q;
    assign event_oe_n = event_oe_n_q;

endmodule : spd_eeprom_temp_sensor_slave

`default_nettype wire

// ==== test/spd_slave_props.sv ====
// Checker for the bus and alert pins of the memory and sensor slave.
`timescale 1ns/100ps
`default_nettype none
module spd_slave_props #(
    parameter int TOUT_CYC = 2000 // Bus timeout in ref_clk cycles.
) (
    input wire logic ref_clk, // System clock.
    input wire logic reset, // Asynchronous reset.
    input wire logic scl_clk, // Serial clock.
    input wire logic sda_i, // Data wire level.
    input wire logic sda_o, // Data drive value.
    input wire logic sda_oe_n, // Low while data is pulled.
    input wire logic [2:0] address_select_inputs, // Strap pins.
    input wire logic [10:0] temp_in, // Converter result.
    input wire logic event_o, // Alert drive value.
    input wire logic event_oe_n // Low while alert is pulled.
);
    logic [31:0] low_q; // Cycles the serial clock has been low.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            low_q <= 32'h0;
        end else begin
            low_q <= scl_clk ? 32'h0 : low_q + 32'h1;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_sda_low;
        sda_o == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data drive value not low");
    property p_event_low;
        event_o == 1'b0;
    endproperty
    a_event_low: assert property (p_event_low) else $error("alert drive value not low");
    property p_sda_idle;
        $fell(reset) |-> sda_oe_n [*3];
    endproperty
    a_sda_idle: assert property (p_sda_idle) else $error("data pulled after reset");
    property p_event_idle;
        $fell(reset) |-> event_oe_n [*2];
    endproperty
    a_event_idle: assert property (p_event_idle) else $error("alert set after reset");
    property p_change_low;
        $changed(sda_oe_n) |-> !scl_clk && !$past(scl_clk, 2);
    endproperty
    a_change_low: assert property (p_change_low) else $error("data changed near clock high");
    property p_stable_high;
        scl_clk && $past(scl_clk) |-> $stable(sda_oe_n);
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("data moved with clock high");
    // The margin covers the clock synchroniser of the design.
    property p_timeout;
        low_q >= 32'(TOUT_CYC + 8) |-> sda_oe_n;
    endproperty
    a_timeout: assert property (p_timeout) else $error("data held past timeout");
    property p_drive_min;
        $fell(sda_oe_n) |-> !sda_oe_n [*8];
    endproperty
    a_drive_min: assert property (p_drive_min) else $error("data pull too short");
endmodule : spd_slave_props
bind spd_eeprom_temp_sensor_slave spd_slave_props #(.TOUT_CYC(TOUT_CYC)) u_spd_slave_props (
    .ref_clk(ref_clk), .reset(reset), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .address_select_inputs(address_select_inputs),
    .temp_in(temp_in), .event_o(event_o), .event_oe_n(event_oe_n));
`default_nettype wire

// ==== test/spd_host_model.sv ====
// Two-wire bus master model that makes frames and reports what it sees.
`timescale 1ns/100ps
`default_nettype none
module spd_host_model #(
    parameter int Q = 14 // Link clock ticks per quarter serial clock period.
) (
    input wire logic lclk, // Link clock.
    input wire logic sda_w, // Resolved data wire.
    output logic scl, // Serial clock, held high between frames.
    output logic sda_d, // 1 releases the wire, 0 pulls it low.
    output logic [7:0] res, // Last byte or acknowledge seen.
    output logic res_ev // Toggles when res is new.
);
    initial begin
        scl = 1'b1;
        sda_d = 1'b1;
        res = 8'h00;
        res_ev = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
    endtask : tick
    // Data moves only in the middle of the low phase, so it never forms a stop.
    task automatic bit_x(input logic b, output logic s);
        tick(Q);
        sda_d = b;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        s = sda_w;
        tick(Q);
        scl = 1'b0;
    endtask : bit_x
    task automatic start();
        tick(Q);
        sda_d = 1'b1;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_d = 1'b0;
        tick(Q);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        tick(Q);
        sda_d = 1'b0;
        tick(Q);
        scl = 1'b1;
        tick(Q);
        sda_d = 1'b1;
        tick(Q);
    endtask : stop
    task automatic xfer(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
        end
        bit_x(1'b1, s);
        res = {7'h00, s};
        res_ev = ~res_ev;
    endtask : xfer
    task automatic recv(input logic ack);
        logic [7:0] v;
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            v[i] = s;
        end
        bit_x(ack, s);
        res = v;
        res_ev = ~res_ev;
    endtask : recv
endmodule : spd_host_model
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the memory and temperature sensor slave.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int CONV = 200;
    localparam int TOUT = 2000;
    localparam logic [31:0] ROWS [9] = '{32'h0000_3001, 32'h0001_1500, 32'h0001_0801,
        32'h0005_1501, 32'h0005_3000, 32'h0023_0801, 32'h0003_1500, 32'h0003_0800,
        32'h0023_0801};
    logic ref_clk = 1'b0;
    logic lclk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strap = 3'h0;
    logic [10:0] temp_in = 11'h000;
    logic sda_o, sda_oe_n, event_o, event_oe_n, scl, sda_d, res_ev;
    logic [7:0] res;
    logic [15:0] q[$];
    int miscompares = 0;
    int checks = 0;
    wire logic sda_w = sda_d & (sda_oe_n | sda_o);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #3.3;
        forever #7.5 lclk = ~lclk;
    end
    spd_eeprom_temp_sensor_slave #(.CONV_CYC(CONV), .TOUT_CYC(TOUT)) u_spd_eeprom_temp_sensor_slave (
        .ref_clk(ref_clk), .reset(reset), .scl_clk(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .address_select_inputs(strap), .temp_in(temp_in),
        .event_o(event_o), .event_oe_n(event_oe_n));
    spd_host_model u_spd_host_model (.lclk(lclk), .sda_w(sda_w), .scl(scl), .sda_d(sda_d),
        .res(res), .res_ev(res_ev));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // The model's own start-up value of the toggle is not a result, so reset masks it.
    always @(res_ev) begin
        if (!reset) begin
            check({8'h00, res}, q.size() > 0 ? q.pop_front() : 16'hDEAD);
        end
    end
    task automatic send(input logic [7:0] b, input logic [7:0] e);
        q.push_back({8'h00, e});
        u_spd_host_model.xfer(b);
    endtask : send
    task automatic get(input logic [7:0] e, input logic ack);
        q.push_back({8'h00, e});
        u_spd_host_model.recv(ack);
    endtask : get
    task automatic head(input logic [3:0] t, input logic [7:0] p);
        u_spd_host_model.start();
        send({t, strap, 1'b0}, 8'h00);
        send(p, 8'h00);
    endtask : head
    task automatic mem_wr(input logic [7:0] off, input logic [7:0] d, input logic e);
        head(spd_pkg::TYPE_MEM, off);
        send(d, {7'h00, e});
        u_spd_host_model.stop();
    endtask : mem_wr
    task automatic ts_wr(input logic [7:0] p, input logic [15:0] w, input logic e);
        head(spd_pkg::TYPE_TS, p);
        send(w[15:8], {7'h00, e});
        send(w[7:0], {7'h00, e});
        u_spd_host_model.stop();
    endtask : ts_wr
    task automatic rd(input logic [3:0] t, input logic [7:0] p, input logic [15:0] w);
        head(t, p);
        u_spd_host_model.start();
        send({t, strap, 1'b1}, 8'h00);
        if (t == spd_pkg::TYPE_TS) begin
            get(w[15:8], 1'b0);
        end
        get(w[7:0], 1'b1);
        u_spd_host_model.stop();
    endtask : rd
    task automatic cmd(input logic [2:0] c, input logic r, input logic e);
        u_spd_host_model.start();
        send({spd_pkg::TYPE_CMD, c, r}, {7'h00, e});
        u_spd_host_model.stop();
    endtask : cmd
    initial begin
        #1800000;
        miscompares++;
        wrap_up();
    end
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        logic [10:0] t;
        void'($urandom(32'h4BB04BAE));
        a = 8'($urandom);
        b = 8'($urandom);
        t = 11'($urandom);
        @(negedge ref_clk);
        strap = 3'($urandom);
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        check({14'h0, sda_oe_n, event_oe_n}, 16'h0003);
        check({14'h0, sda_o, event_o}, 16'h0000);
        repeat (4) @(negedge ref_clk);
        mem_wr(8'h7F, a, 1'b0);
        mem_wr(8'h80, b, 1'b0);
        cmd(3'h1, 1'b0, 1'b0);
        mem_wr(8'h80, ~b, 1'b1);
        mem_wr(8'h7F, ~a, 1'b0);
        rd(spd_pkg::TYPE_MEM, 8'h80, {8'h00, b});
        cmd(spd_pkg::CMD_CLR_WP, 1'b0, 1'b0);
        mem_wr(8'h80, ~b, 1'b0);
        rd(spd_pkg::TYPE_MEM, 8'h80, {8'h00, ~b});
        cmd(spd_pkg::CMD_PAGE0, 1'b1, 1'b0);
        cmd(spd_pkg::CMD_PAGE1, 1'b0, 1'b0);
        cmd(spd_pkg::CMD_PAGE0, 1'b1, 1'b1);
        cmd(spd_pkg::CMD_PAGE1, 1'b1, 1'b0);
        mem_wr(8'h7F, b, 1'b0);
        rd(spd_pkg::TYPE_MEM, 8'h7F, {8'h00, b});
        cmd(spd_pkg::CMD_PAGE0, 1'b0, 1'b0);
        rd(spd_pkg::TYPE_MEM, 8'h7F, {8'h00, ~a});
        mem_wr(8'h20, 8'h00, 1'b0);
        u_spd_host_model.start();
        send({spd_pkg::TYPE_MEM, strap ^ 3'h1, 1'b0}, 8'h01);
        send(8'h7F, 8'h01);
        u_spd_host_model.stop();
        @(negedge ref_clk);
        temp_in = t;
        repeat (CONV * 2 + 10) @(negedge ref_clk);
        rd(spd_pkg::TYPE_TS, spd_pkg::PTR_TEMP, {{5{t[10]}}, t});
        ts_wr(spd_pkg::PTR_TEMP, 16'h1234, 1'b1);
        rd(spd_pkg::TYPE_TS, spd_pkg::PTR_CAP, spd_pkg::CAP_VALUE);
        ts_wr(spd_pkg::PTR_UPPER, 16'h0100, 1'b0);
        ts_wr(spd_pkg::PTR_CRIT, 16'h0200, 1'b0);
        foreach (ROWS[i]) begin
            @(negedge ref_clk);
            temp_in = ROWS[i][14:4];
            repeat (CONV * 2 + 10) @(negedge ref_clk);
            ts_wr(spd_pkg::PTR_CFG, ROWS[i][31:16], 1'b0);
            repeat (4) @(negedge ref_clk);
            check({15'h0, event_oe_n}, {15'h0, ROWS[i][0]});
        end
        // Each read leaves the device driving a zero bit while the clock is held low.
        for (int k = 0; k < 2; k++) begin
            if (k == 0) begin
                head(spd_pkg::TYPE_MEM, 8'h20);
            end else begin
                head(spd_pkg::TYPE_TS, spd_pkg::PTR_TEMP);
            end
            u_spd_host_model.start();
            send({k ? spd_pkg::TYPE_TS : spd_pkg::TYPE_MEM, strap, 1'b1}, 8'h00);
            repeat (8) @(negedge ref_clk);
            check({15'h0, sda_oe_n}, 16'h0000);
            repeat (TOUT + 10) @(negedge ref_clk);
            check({15'h0, sda_oe_n}, 16'h0001);
            u_spd_host_model.stop();
        end
        repeat (4) @(negedge ref_clk);
        check(16'(q.size()), 16'h0000);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
